/* File: hw/lse_params.svh */
`ifndef LSE_PARAMS_SVH
`define LSE_PARAMS_SVH

// Register byte offsets on the APB bus
`define LSE_OFS_CTRL 8'h00
`define LSE_OFS_ENCSEL 8'h04
`define LSE_OFS_PRESC 8'h08
`define LSE_OFS_XORG 8'h0C
`define LSE_OFS_YORG 8'h10
`define LSE_OFS_XSIZE 8'h14
`define LSE_OFS_YSIZE 8'h18
`define LSE_OFS_AUX 8'h1C
`define LSE_OFS_TRAILER 8'h20
`define LSE_OFS_STATUS 8'h24

// Control register fields
`define LSE_CTRL_EN 0
`define LSE_CTRL_CLOCKED 1
`define LSE_RST_CTRL 2'h1

// Auxiliary control fields
`define LSE_AUX_CONT 5
`define LSE_AUX_BYP 6
`define LSE_AUX_GSEL 7
`define LSE_RST_AUX 8'h1F

// Other reset values
`define LSE_RST_PRESC 10'h000
`define LSE_RST_ENCSEL 5'h00
`define LSE_RST_ORG 10'h000
`define LSE_RST_XSIZE 10'h100
`define LSE_RST_YSIZE 10'h020
`define LSE_RST_TRAILER 5'h00

// One-wire encoding codes
`define LSE_ENC_FAST_A 5'h01
`define LSE_ENC_FAST_B 5'h10

// Clock rates in kHz; strip tick comes from a fractional accumulator
`define LSE_MCLK_KHZ 200000
`define LSE_STRIP_KHZ 25600
`define LSE_ACC_STEP (`LSE_STRIP_KHZ / 1600)
`define LSE_ACC_MOD (`LSE_MCLK_KHZ / 1600)

// A bit slot is split into this many phases
`define LSE_PHASES 32
`define LSE_PIX_BITS 24
`define LSE_TRAIL_MULT 32

// Slot periods and high times in ns
`define LSE_SLOT_FAST_NS 1250
`define LSE_SLOT_SLOW_NS 2500
`define LSE_A_T0H_NS 350
`define LSE_A_T1H_NS 700
`define LSE_B_T0H_NS 300
`define LSE_B_T1H_NS 790
`define LSE_S_T0H_NS 500
`define LSE_S_T1H_NS 1200

// High phases, rounded up to whole phases
`define LSE_HI_PH(ns, slot) (((ns) * `LSE_PHASES + (slot) - 1) / (slot))

`endif

/* File: hw/lse_pkg.sv */
package lse_pkg;

    // Serializer states, Gray along idle-shift-trail
    typedef enum logic [1:0] {
        LSE_IDLE = 2'b00,
        LSE_SHIFT = 2'b01,
        LSE_TRAIL = 2'b11
    } lse_state_e;

    // Incoming video pixel with its coordinates
    typedef struct packed {
        logic [9:0] x;
        logic [9:0] y;
        logic [23:0] rgb;
    } lse_vid_s;

    // Pixel held in the buffer
    typedef struct packed {
        logic [23:0] rgb;
        logic eol;
    } lse_pix_s;

    // Settings image kept in non-volatile storage
    typedef struct packed {
        logic [9:0] presc;
        logic [4:0] encsel;
        logic [9:0] x_org;
        logic [9:0] y_org;
        logic [9:0] x_size;
        logic [9:0] y_size;
        logic [7:0] aux;
        logic [4:0] trailer;
    } lse_cfg_s;

endpackage

/* File: hw/lse_buf.sv */
`timescale 1ns/10ps
`default_nettype none

module lse_buf #(
    parameter int W = 25,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;

    // Handshake decode
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];

    // Pointer step with wrap at the depth
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Storage and pointers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                mem[wp] <= in_data_i;
                wp <= step(wp);
            end
            if (pop) begin
                rp <= step(rp);
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

`default_nettype wire

/* File: hw/lse_encoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lse_params.svh"

// What this block does
// - Five-bit brightness in aux bits 4-0, applied in one-wire mode only, 31 brightest, resets to 31.
// - Gamma bypass bit set skips correction; clear applies internal gamma.
// - In one-wire mode gamma select picks PC curve (0) or MAC curve (1).
// - Clocked mode: continuous clock bit keeps strip clock running when idle.
// - Clocked mode: each line ends with 32 times trailer-count ones.
// - Trailer count does nothing in one-wire mode.
// - Only pixels inside the programmed crop window are passed on.
// - Settings image is exported and restorable at power-up.
// - Bit slot length scales with prescaler setting plus one.
// - Each pixel is exactly 24 bit slots, RGB888 shifted serially.
// - Code 0x01: first family, high 0.35 us or 0.7 us.
// - Code 0x10: second family shape, 800 kHz bit period kept.
// - Code 0x00: slow shape, high 0.5 us or 1.2 us.
// - Encoding code is a write-only five-bit field resetting to zero.
// - Prescaler 0 gives 800 kHz bits, 1 gives 400 kHz.
module lse_encoder
    import lse_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Video input stream
    input wire logic vid_valid_i,
    input wire lse_vid_s vid_i,
    output logic vid_ready_o,
    // Settings store
    input wire logic nv_load_i,
    input wire lse_cfg_s nv_image_i,
    output lse_cfg_s nv_image_o,
    // Strip pins
    output logic strip_line_o,
    output logic strip_clk_o,
    output logic strip_data_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    logic [1:0] ctrl;
    lse_cfg_s cfg;
    lse_state_e state, next_state;
    logic [6:0] acc;
    logic [9:0] presc_cnt;
    logic [4:0] phase;
    logic [23:0] shreg, next_shreg;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic eol_cur, next_eol_cur;
    logic [9:0] trail_cnt, next_trail_cnt;
    logic next_line, next_clk, next_dat;

    // Window test: value lies in [org, org+size)
    function automatic logic in_range(input logic [9:0] v, input logic [9:0] o, input logic [9:0] s);
        in_range = (v >= o) && ({1'b0, v} < ({1'b0, o} + {1'b0, s}));
    endfunction

    // Gamma then brightness for one colour component
    function automatic logic [7:0] comp(input logic [7:0] c, input logic [7:0] aux, input logic ow);
        logic [15:0] sq;
        logic [8:0] mac;
        logic [7:0] gc;
        logic [12:0] sc;
        sq = c * c;
        mac = {1'b0, sq[15:8]} + {1'b0, c};
        gc = (aux[`LSE_AUX_GSEL] && ow) ? mac[8:1] : sq[15:8];
        if (aux[`LSE_AUX_BYP]) begin
            gc = c;
        end
        sc = 13'(gc) * 13'({1'b0, aux[4:0]} + 6'd1);
        comp = ow ? sc[12:5] : gc;
    endfunction

    // APB decode; the slave never inserts wait states
    wire acc_ph = psel_i && penable_i;
    wire hit_ctrl = (paddr_i == `LSE_OFS_CTRL);
    wire hit_enc = (paddr_i == `LSE_OFS_ENCSEL);
    wire hit_presc = (paddr_i == `LSE_OFS_PRESC);
    wire hit_xorg = (paddr_i == `LSE_OFS_XORG);
    wire hit_yorg = (paddr_i == `LSE_OFS_YORG);
    wire hit_xsize = (paddr_i == `LSE_OFS_XSIZE);
    wire hit_ysize = (paddr_i == `LSE_OFS_YSIZE);
    wire hit_aux = (paddr_i == `LSE_OFS_AUX);
    wire hit_trl = (paddr_i == `LSE_OFS_TRAILER);
    wire hit_stat = (paddr_i == `LSE_OFS_STATUS);
    wire mapped = hit_ctrl || hit_enc || hit_presc || hit_xorg || hit_yorg || hit_xsize
                  || hit_ysize || hit_aux || hit_trl || hit_stat;
    wire wr = acc_ph && pwrite_i && mapped;
    assign pready_o = 1'b1;
    assign pslverr_o = acc_ph && !mapped;

    wire enable = ctrl[`LSE_CTRL_EN];
    wire clocked = ctrl[`LSE_CTRL_CLOCKED];
    wire ow = !clocked;

    // Read mux taken in the setup phase and registered, so read data leaves a flop with no wait state
    // write-only code
    wire buf_valid;
    wire rd_setup = psel_i && !penable_i && !pwrite_i;
    wire [31:0] rd_word = !rd_setup ? 32'h0 :
                      hit_ctrl ? {30'h0, ctrl} :
                      hit_presc ? {22'h0, cfg.presc} :
                      hit_xorg ? {22'h0, cfg.x_org} :
                      hit_yorg ? {22'h0, cfg.y_org} :
                      hit_xsize ? {22'h0, cfg.x_size} :
                      hit_ysize ? {22'h0, cfg.y_size} :
                      hit_aux ? {24'h0, cfg.aux} :
                      hit_trl ? {27'h0, cfg.trailer} :
                      hit_stat ? {27'h0, eol_cur, buf_valid, 1'b0, state} : 32'h0;

    // Read data register; zero outside a read so the bus idles low
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0;
        end else begin
            prdata_o <= rd_word;
        end
    end

    // Settings registers; a restore from the store wins over software
    // reserved bits dropped
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `LSE_RST_CTRL;
            cfg <= '{`LSE_RST_PRESC, `LSE_RST_ENCSEL, `LSE_RST_ORG, `LSE_RST_ORG,
                     `LSE_RST_XSIZE, `LSE_RST_YSIZE, `LSE_RST_AUX, `LSE_RST_TRAILER};
        end else if (nv_load_i) begin
            cfg <= nv_image_i;
        end else if (wr) begin
            if (hit_ctrl) ctrl <= pwdata_i[1:0];
            if (hit_enc) cfg.encsel <= pwdata_i[4:0];
            if (hit_presc) cfg.presc <= pwdata_i[9:0];
            if (hit_xorg) cfg.x_org <= pwdata_i[9:0];
            if (hit_yorg) cfg.y_org <= pwdata_i[9:0];
            if (hit_xsize) cfg.x_size <= pwdata_i[9:0];
            if (hit_ysize) cfg.y_size <= pwdata_i[9:0];
            if (hit_aux) cfg.aux <= pwdata_i[7:0];
            if (hit_trl) cfg.trailer <= pwdata_i[4:0];
        end
    end
    assign nv_image_o = cfg;

    // Crop window; pixels outside it are taken and dropped
    // crop window
    wire in_win = in_range(vid_i.x, cfg.x_org, cfg.x_size) && in_range(vid_i.y, cfg.y_org, cfg.y_size);
    wire at_eol = ({1'b0, vid_i.x} + 11'd1) == ({1'b0, cfg.x_org} + {1'b0, cfg.x_size});
    wire buf_in_ready;
    wire push = vid_valid_i && in_win;
    assign vid_ready_o = in_win ? buf_in_ready : 1'b1;

    // Two-entry buffer absorbs stalls of the serializer
    wire pop;
    lse_pix_s buf_out;
    lse_buf #(.W($bits(lse_pix_s)), .DEPTH(2)) lse_buf_inst (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_data_i({vid_i.rgb, at_eol}),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_valid),
        .out_data_o(buf_out),
        .out_ready_i(pop)
    );

    // Strip tick at 25.6 MHz from 200 MHz: add 16, wrap at 125
    // fixed strip tick
    wire run = (state != LSE_IDLE) || (clocked && cfg.aux[`LSE_AUX_CONT] && enable);
    wire [7:0] acc_sum = {1'b0, acc} + 8'(`LSE_ACC_STEP);
    wire tick = run && (acc_sum >= 8'(`LSE_ACC_MOD));
    wire ph_step = tick && (presc_cnt == cfg.presc);
    wire slot_end = ph_step && (phase == 5'(`LSE_PHASES - 1));

    // Timing counters; they restart with every burst except under a continuous clock, so slots align to the data
    // prescaler rate
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= '0;
            presc_cnt <= '0;
            phase <= '0;
        end else if (!run) begin
            acc <= '0;
            presc_cnt <= '0;
            phase <= '0;
        end else begin
            acc <= tick ? 7'(acc_sum - 8'(`LSE_ACC_MOD)) : acc_sum[6:0];
            presc_cnt <= !tick ? presc_cnt : (ph_step ? 10'h000 : presc_cnt + 10'h001);
            phase <= ph_step ? phase + 5'h01 : phase;
        end
    end

    // Processed colour word, red first
    // brightness field
    wire [23:0] pix = {comp(buf_out.rgb[23:16], cfg.aux, ow), comp(buf_out.rgb[15:8], cfg.aux, ow),
                       comp(buf_out.rgb[7:0], cfg.aux, ow)};
    wire last_bit = (bit_cnt == 5'(`LSE_PIX_BITS - 1));
    wire go_trail = eol_cur && clocked && (cfg.trailer != 5'h00);
    // A free-running clock makes an idle start wait for a slot edge, else the first bit is cut short
    wire idle_take = (state == LSE_IDLE) && (!run || slot_end);
    assign pop = buf_valid && enable && (idle_take ||
                 (state == LSE_SHIFT && slot_end && last_bit && !go_trail));

    // Serializer sequencing
    // 24 slots per pixel
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_eol_cur = eol_cur;
        next_trail_cnt = trail_cnt;
        unique case (state)
            LSE_IDLE: begin
                if (pop) begin
                    next_state = LSE_SHIFT;
                end
            end
            LSE_SHIFT: begin
                if (slot_end && !last_bit) begin
                    next_shreg = {shreg[22:0], 1'b0};
                    next_bit_cnt = bit_cnt + 5'h01;
                end else if (slot_end && go_trail) begin
                    next_state = LSE_TRAIL;
                    next_trail_cnt = 10'(cfg.trailer * `LSE_TRAIL_MULT);
                end else if (slot_end && !pop) begin
                    next_state = LSE_IDLE;
                end
            end
            LSE_TRAIL: begin
                if (slot_end) begin
                    next_trail_cnt = trail_cnt - 10'h001;
                    next_state = (trail_cnt == 10'h001) ? LSE_IDLE : LSE_TRAIL;
                end
            end
            default: begin
                next_state = LSE_IDLE;
            end
        endcase
        if (pop) begin
            next_shreg = pix;
            next_bit_cnt = 5'h00;
            next_eol_cur = buf_out.eol;
        end
    end

    // High phases per code and bit value
    // first family
    wire fam_a = (cfg.encsel == `LSE_ENC_FAST_A);
    wire fam_b = (cfg.encsel == `LSE_ENC_FAST_B);
    wire [5:0] hi_a = shreg[23] ? 6'(`LSE_HI_PH(`LSE_A_T1H_NS, `LSE_SLOT_FAST_NS))
                                : 6'(`LSE_HI_PH(`LSE_A_T0H_NS, `LSE_SLOT_FAST_NS));
    wire [5:0] hi_b = shreg[23] ? 6'(`LSE_HI_PH(`LSE_B_T1H_NS, `LSE_SLOT_FAST_NS))
                                : 6'(`LSE_HI_PH(`LSE_B_T0H_NS, `LSE_SLOT_FAST_NS));
    wire [5:0] hi_s = shreg[23] ? 6'(`LSE_HI_PH(`LSE_S_T1H_NS, `LSE_SLOT_SLOW_NS))
                                : 6'(`LSE_HI_PH(`LSE_S_T0H_NS, `LSE_SLOT_SLOW_NS));
    wire [5:0] hi_ph = fam_a ? hi_a : (fam_b ? hi_b : hi_s);

    // Pin values; clock is low in the first half slot so data settles first
    // continuous clock
    assign next_line = ow && (state == LSE_SHIFT) && ({1'b0, phase} < hi_ph);
    assign next_clk = clocked && run && phase[4];
    assign next_dat = clocked && ((state == LSE_TRAIL) || (state == LSE_SHIFT && shreg[23]));

    // Serializer and pin registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= LSE_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            eol_cur <= 1'b0;
            trail_cnt <= '0;
            strip_line_o <= 1'b0;
            strip_clk_o <= 1'b0;
            strip_data_o <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            eol_cur <= next_eol_cur;
            trail_cnt <= next_trail_cnt;
            strip_line_o <= next_line;
            strip_clk_o <= next_clk;
            strip_data_o <= next_dat;
        end
    end

    AST_TICK_SPACING: assert property (tick |=> !tick [*6])
        else $error("strip ticks too close");
    AST_PRESC_BOUND: assert property (run |-> presc_cnt <= cfg.presc)
        else $error("prescaler count overran setting");
    AST_BIT_STEP: assert property ((state == LSE_SHIFT && slot_end && !last_bit)
        |=> bit_cnt == $past(bit_cnt) + 5'h01)
        else $error("bit counter did not advance");
    AST_TRAIL_HIGH: assert property (state == LSE_TRAIL |=> strip_data_o)
        else $error("trailer bit not one");
    AST_TRAIL_CLOCKED: assert property (state == LSE_TRAIL |-> clocked)
        else $error("trailer in one-wire mode");
    AST_LINE_HIGH: assert property ((ow && state == LSE_SHIFT && fam_a && phase == 5'h00)
        |=> strip_line_o)
        else $error("one-wire bit did not start high");
    AST_ENC_READ: assert property ((acc_ph && !pwrite_i && hit_enc) |-> prdata_o == 32'h0)
        else $error("encoding code readable");
    AST_AUX_RESV: assert property ((acc_ph && !pwrite_i && hit_aux) |-> prdata_o[31:8] == 24'h0)
        else $error("reserved aux bits not zero");
    AST_CROP_PUSH: assert property ((push && buf_in_ready)
        |-> in_range(vid_i.x, cfg.x_org, cfg.x_size))
        else $error("pixel outside window stored");
    AST_GATED_CLK: assert property ((clocked && !cfg.aux[`LSE_AUX_CONT] && state == LSE_IDLE
        && $past(state) == LSE_IDLE) |=> !strip_clk_o)
        else $error("clock runs while idle");
endmodule

`default_nettype wire

/* File: tb/lse_strip_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Stand-in for the pixel chain: times one-wire pulses and samples clocked data
module lse_strip_model (
    // Clock
    input wire logic mclk_i,
    // Strip pins
    input wire logic line_i,
    input wire logic clk_i,
    input wire logic data_i
);
    int hi_q[$];
    int per_q[$];
    logic cb_q[$];
    int hi_n = 0;
    int per_n = 0;
    logic line_d = 1'b0;
    logic clk_d = 1'b0;

    // Widths and rise spacing counted in mclk cycles; pixels only listen
    always @(posedge mclk_i) begin
        per_n <= per_n + 1;
        if (line_i === 1'b1) begin
            hi_n <= hi_n + 1;
        end
        if (line_i === 1'b1 && line_d !== 1'b1) begin
            per_q.push_back(per_n);
            per_n <= 1;
            hi_n <= 1;
        end
        if (line_i !== 1'b1 && line_d === 1'b1) begin
            hi_q.push_back(hi_n);
        end
        // Clocked pixels take data on the rising strip clock
        if (clk_i === 1'b1 && clk_d !== 1'b1) begin
            cb_q.push_back(data_i);
        end
        line_d <= line_i;
        clk_d <= clk_i;
    end
endmodule

`default_nettype wire

/* File: tb/test_lse_encoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lse_params.svh"

module test_lse_encoder
    import lse_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vid_valid = 1'b0;
    lse_vid_s vid = '0;
    logic vid_ready;
    logic nv_load = 1'b0;
    lse_cfg_s nv_in = '0;
    lse_cfg_s nv_out;
    logic s_line;
    logic s_clk;
    logic s_data;
    logic refused = 1'b0;
    logic [23:0] exp_q[$];
    int failures = 0;
    int check_count = 0;
    logic [4:0] codes[3] = '{`LSE_ENC_FAST_A, `LSE_ENC_FAST_B, 5'h00};
    int pr[3] = '{0, 0, 1};
    int h0[3] = '{350, 300, 500};
    int h1[3] = '{700, 790, 1200};
    int sl[3] = '{1250, 1250, 2500};

    lse_encoder lse_encoder_inst (
        .mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .vid_valid_i(vid_valid), .vid_i(vid),
        .vid_ready_o(vid_ready), .nv_load_i(nv_load), .nv_image_i(nv_in),
        .nv_image_o(nv_out), .strip_line_o(s_line), .strip_clk_o(s_clk), .strip_data_o(s_data)
    );

    lse_strip_model lse_strip_model_inst (
        .mclk_i(mclk), .line_i(s_line), .clk_i(s_clk), .data_i(s_data)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [79:0] got, input logic [79:0] want, input string what);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic near(input int got, input int want, input int tol, input string what);
        check_count++;
        if (got > want + tol || got < want - tol) begin
            failures++;
            $display("MISMATCH %0t %s got %0d want %0d", $time, what, got, want);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // Unmapped reads are judged on the error flag alone
    task automatic rdc(input logic [7:0] a, input logic [31:0] want, input logic werr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        if (!werr) chk(r, want, "read data");
        chk(e, werr, "slave error");
    endtask

    task automatic send_pix(input logic [9:0] x, input logic [9:0] y, input logic [23:0] c);
        @(posedge mclk);
        vid_valid <= 1'b1;
        vid <= {x, y, c};
        @(posedge mclk);
        while (vid_ready !== 1'b1) begin
            refused = 1'b1;
            @(posedge mclk);
        end
        vid_valid <= 1'b0;
    endtask

    // Poll status until serializer idle and buffer empty
    task automatic wait_idle();
        logic [31:0] r;
        logic e;
        int n;
        r = 32'h1;
        n = 0;
        while ((r[1:0] !== 2'b00 || r[3] !== 1'b0) && n < 30000) begin
            apb(1'b0, `LSE_OFS_STATUS, 32'h0, r, e);
            n++;
        end
        repeat (300) @(posedge mclk);
    endtask

    task automatic clear_model();
        lse_strip_model_inst.hi_q.delete();
        lse_strip_model_inst.per_q.delete();
        lse_strip_model_inst.cb_q.delete();
    endtask

    // Bit by bit: high time picks the value, rises keep the slot period
    task automatic check_line(input int hi0, input int hi1, input int slot, input int tol);
        int n;
        n = 24 * exp_q.size();
        near(lse_strip_model_inst.hi_q.size(), n, 0, "pulse count");
        for (int i = 0; i < n && i < lse_strip_model_inst.hi_q.size(); i++) begin
            near(lse_strip_model_inst.hi_q[i] * 5, exp_q[i / 24][23 - i % 24] ? hi1 : hi0, tol, "high ns");
            if (i > 0) near(lse_strip_model_inst.per_q[i] * 5, slot, 10, "slot ns");
        end
        exp_q.delete();
        clear_model();
    endtask

    task automatic give_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized from the expected pixel traffic
    initial begin
        repeat (95000) @(posedge mclk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(`LSE_OFS_AUX, 32'h1F, 1'b0);
        rdc(`LSE_OFS_TRAILER, 32'h0, 1'b0);
        rdc(`LSE_OFS_PRESC, 32'h0, 1'b0);
        wr(`LSE_OFS_ENCSEL, 32'h1F);
        rdc(`LSE_OFS_ENCSEL, 32'h0, 1'b0);
        rdc(8'h28, 32'h0, 1'b1);
        wr(`LSE_OFS_AUX, 32'hFFFFFFFF);
        rdc(`LSE_OFS_AUX, 32'hFF, 1'b0);
        wr(`LSE_OFS_TRAILER, 32'hFFFF);
        rdc(`LSE_OFS_TRAILER, 32'h1F, 1'b0);
        // Trailer left nonzero: one-wire lines must not grow
        wr(`LSE_OFS_TRAILER, 32'h1);
        wr(`LSE_OFS_XSIZE, 32'h1);
        wr(`LSE_OFS_YSIZE, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wr(`LSE_OFS_ENCSEL, {27'h0, codes[k]});
            wr(`LSE_OFS_PRESC, pr[k]);
            wr(`LSE_OFS_AUX, 32'h5F);
            // First pass: with the block disabled the pixel must wait in the buffer
            if (k == 0) wr(`LSE_OFS_CTRL, 32'h0);
            send_pix(10'h0, 10'h0, 24'hA5C30F);
            if (k == 0) begin
                repeat (300) @(posedge mclk);
                rdc(`LSE_OFS_STATUS, 32'h8, 1'b0);
                wr(`LSE_OFS_CTRL, 32'h1);
            end
            exp_q.push_back(24'hA5C30F);
            wait_idle();
            check_line(h0[k], h1[k], sl[k], 40 * (pr[k] + 1) + 10);
        end
        // Gamma curves, full brightness
        wr(`LSE_OFS_ENCSEL, 32'h1);
        wr(`LSE_OFS_PRESC, 32'h0);
        wr(`LSE_OFS_AUX, 32'h1F);
        send_pix(10'h0, 10'h0, 24'h804000);
        exp_q.push_back(24'h401000);
        wait_idle();
        check_line(350, 700, 1250, 50);
        wr(`LSE_OFS_AUX, 32'h9F);
        send_pix(10'h0, 10'h0, 24'h804000);
        exp_q.push_back(24'h602800);
        wait_idle();
        check_line(350, 700, 1250, 50);
        // Window x 1..4 at half brightness; back to back fills the buffer
        wr(`LSE_OFS_XORG, 32'h1);
        wr(`LSE_OFS_XSIZE, 32'h4);
        wr(`LSE_OFS_AUX, 32'h4F);
        refused = 1'b0;
        for (int x = 0; x < 6; x++) begin
            send_pix(10'(x), 10'h0, 24'hFF2040);
            if (x > 0 && x < 5) exp_q.push_back(24'h7F1020);
        end
        send_pix(10'h2, 10'h1, 24'hFF2040);
        wait_idle();
        chk(refused, 1'b1, "buffer refusal");
        check_line(350, 700, 1250, 50);
        // Clocked mode: pixel then 32 trailing ones
        wr(`LSE_OFS_XORG, 32'h0);
        wr(`LSE_OFS_XSIZE, 32'h1);
        wr(`LSE_OFS_CTRL, 32'h3);
        wr(`LSE_OFS_AUX, 32'h5F);
        repeat (300) @(posedge mclk);
        clear_model();
        send_pix(10'h0, 10'h0, 24'hA5C30F);
        wait_idle();
        near(lse_strip_model_inst.cb_q.size(), 24 + 32, 0, "clock count");
        for (int i = 0; i < 56 && i < lse_strip_model_inst.cb_q.size(); i++) begin
            chk(lse_strip_model_inst.cb_q[i], i < 24 ? 24'hA5C30F >> (23 - i) & 1 : 1'b1, "clocked bit");
        end
        // Continuous clock runs while idle, stops when cleared
        wr(`LSE_OFS_AUX, 32'h7F);
        clear_model();
        repeat (2000) @(posedge mclk);
        chk(lse_strip_model_inst.cb_q.size() > 4, 1'b1, "free clock");
        wr(`LSE_OFS_AUX, 32'h5F);
        repeat (300) @(posedge mclk);
        clear_model();
        repeat (2000) @(posedge mclk);
        near(lse_strip_model_inst.cb_q.size(), 0, 0, "idle clock");
        // Settings restored from the stored image
        @(posedge mclk);
        nv_load <= 1'b1;
        nv_in <= {10'h0, 5'h01, 10'h3, 10'h2, 10'h8, 10'h4, 8'h4A, 5'h07};
        @(posedge mclk);
        nv_load <= 1'b0;
        rdc(`LSE_OFS_XORG, 32'h3, 1'b0);
        rdc(`LSE_OFS_AUX, 32'h4A, 1'b0);
        chk(nv_out, nv_in, "stored image");
        give_verdict();
    end
endmodule

`default_nettype wire
